// ===== hdl/mbs_brake_seq.sv
// Behaviour
// - sequencing on suppresses start DC brake, dwell
// - run from stop ramps to directional release frequency
// - release output only once current reaches threshold
// - hold release frequency for release hold, then accelerate
// - stop while running starts deceleration
// - at engage frequency halt and signal engage
// - hold engage frequency, then output zero
// - DC brake if time and level set, then block
// - separate forward/reverse release frequencies, default 1.00 Hz
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module mbs_brake_seq #(
  parameter int TICK_CYCLES = mbs_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [15:0] motor_current,
  output logic [15:0]      out_freq,
  output logic             out_reverse,
  output logic             brake_release,
  output logic             dc_brake_active,
  output logic [15:0]      dc_brake_level,
  output logic             output_block,
  output logic             start_dcb_inhibit,
  output logic             dwell_inhibit
);

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [2:0]  ctrl;
  logic [15:0] rel_current;
  logic [15:0] rel_hold;
  logic [15:0] rel_fwd;
  logic [15:0] rel_rev;
  logic [15:0] eng_hold;
  logic [15:0] eng_freq;
  logic [15:0] target;
  logic [15:0] max_freq;
  logic [15:0] ramp_step;
  logic [15:0] dcb_time;
  logic [15:0] dcb_level_r;
  mbs_pkg::mbs_state_e state;
  mbs_pkg::mbs_state_e next_state;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  wire        setup_rd   = psel && !penable;
  wire        wr_en      = psel && penable && pwrite;
  wire [15:0] wd         = pwdata[15:0];
  wire        seq_en     = ctrl[mbs_pkg::CTRL_SEQ_EN_BIT];
  wire        run_cmd    = ctrl[mbs_pkg::CTRL_RUN_BIT];
  wire        rev_cmd    = ctrl[mbs_pkg::CTRL_REVERSE_BIT];
  wire        addr_ok    = (paddr[1:0] == 2'b00) && (paddr <= mbs_pkg::OFS_STATUS);
  wire        wr_hit     = wr_en && addr_ok && (paddr != mbs_pkg::OFS_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl        <= mbs_pkg::RST_CTRL;
      rel_current <= mbs_pkg::RST_REL_CURRENT;
      rel_hold    <= mbs_pkg::RST_REL_HOLD;
      rel_fwd     <= mbs_pkg::RST_REL_FREQ;
      rel_rev     <= mbs_pkg::RST_REL_FREQ;
      eng_hold    <= mbs_pkg::RST_ENG_HOLD;
      eng_freq    <= mbs_pkg::RST_ENG_FREQ;
      target      <= mbs_pkg::RST_TARGET;
      max_freq    <= mbs_pkg::RST_MAX_FREQ;
      ramp_step   <= mbs_pkg::RST_RAMP_STEP;
      dcb_time    <= mbs_pkg::RST_DCB;
      dcb_level_r <= mbs_pkg::RST_DCB;
    end else if (wr_hit) begin
      case (paddr)
        mbs_pkg::OFS_CTRL:        ctrl        <= pwdata[2:0];
        mbs_pkg::OFS_REL_CURRENT: rel_current <= clamp(wd, mbs_pkg::MAX_REL_CURRENT);
        mbs_pkg::OFS_REL_HOLD:    rel_hold    <= clamp(wd, mbs_pkg::MAX_HOLD_TIME);
        mbs_pkg::OFS_REL_FWD:     rel_fwd     <= clamp(wd, max_freq);
        mbs_pkg::OFS_REL_REV:     rel_rev     <= clamp(wd, max_freq);
        mbs_pkg::OFS_ENG_HOLD:    eng_hold    <= clamp(wd, mbs_pkg::MAX_HOLD_TIME);
        mbs_pkg::OFS_ENG_FREQ:    eng_freq    <= clamp(wd, max_freq);
        mbs_pkg::OFS_TARGET:      target      <= clamp(wd, max_freq);
        mbs_pkg::OFS_MAX_FREQ:    max_freq    <= wd;
        mbs_pkg::OFS_RAMP_STEP:   ramp_step   <= wd;
        mbs_pkg::OFS_DCB_TIME:    dcb_time    <= clamp(wd, mbs_pkg::MAX_HOLD_TIME);
        mbs_pkg::OFS_DCB_LEVEL:   dcb_level_r <= wd;
        default:                  ctrl        <= ctrl;
      endcase
    end
  end

  // ==========================================================================
  // APB answer: read data and error are captured in the setup cycle
  // ==========================================================================
  logic [31:0] rd_mux;
  logic        rd_err;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      mbs_pkg::OFS_CTRL:        rd_mux = {29'h0000_0000, ctrl};
      mbs_pkg::OFS_REL_CURRENT: rd_mux = {16'h0000, rel_current};
      mbs_pkg::OFS_REL_HOLD:    rd_mux = {16'h0000, rel_hold};
      mbs_pkg::OFS_REL_FWD:     rd_mux = {16'h0000, rel_fwd};
      mbs_pkg::OFS_REL_REV:     rd_mux = {16'h0000, rel_rev};
      mbs_pkg::OFS_ENG_HOLD:    rd_mux = {16'h0000, eng_hold};
      mbs_pkg::OFS_ENG_FREQ:    rd_mux = {16'h0000, eng_freq};
      mbs_pkg::OFS_TARGET:      rd_mux = {16'h0000, target};
      mbs_pkg::OFS_MAX_FREQ:    rd_mux = {16'h0000, max_freq};
      mbs_pkg::OFS_RAMP_STEP:   rd_mux = {16'h0000, ramp_step};
      mbs_pkg::OFS_DCB_TIME:    rd_mux = {16'h0000, dcb_time};
      mbs_pkg::OFS_DCB_LEVEL:   rd_mux = {16'h0000, dcb_level_r};
      mbs_pkg::OFS_STATUS: begin
        rd_mux[mbs_pkg::ST_FREQ_LSB +: 16] = out_freq;
        rd_mux[mbs_pkg::ST_STATE_LSB +: 4] = state;
        rd_mux[mbs_pkg::ST_RELEASE_BIT]    = brake_release;
        rd_mux[mbs_pkg::ST_DCB_BIT]        = dc_brake_active;
        rd_mux[mbs_pkg::ST_BLOCK_BIT]      = output_block;
      end
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      rd_err <= 1'b0;
    end else if (setup_rd) begin
      prdata <= addr_ok ? rd_mux : 32'h0000_0000;
      rd_err <= !addr_ok || (pwrite && paddr == mbs_pkg::OFS_STATUS);
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && rd_err;

  // ==========================================================================
  // Hold timer and ramp
  // ==========================================================================
  logic        tmr_start;
  logic [15:0] tmr_load;
  logic        tick;
  logic        tmr_done;

  mbs_hold_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (tmr_start),
    .hold_ticks (tmr_load),
    .tick       (tick),
    .done       (tmr_done)
  );

  function automatic logic [15:0] ramp_to(input logic [15:0] f, input logic [15:0] goal,
                                          input logic [15:0] step);
    if (f < goal)
      ramp_to = (goal - f > step) ? f + step : goal;
    else
      ramp_to = (f - goal > step) ? f - step : goal;
  endfunction

  wire [15:0] rel_freq  = rev_cmd ? rel_rev : rel_fwd;
  wire        dcb_set   = (dcb_time != 16'h0000) && (dcb_level_r != 16'h0000);
  wire        running   = (state == mbs_pkg::ST_ACCEL_REL) || (state == mbs_pkg::ST_WAIT_CURR)
                       || (state == mbs_pkg::ST_REL_HOLD) || (state == mbs_pkg::ST_RUN);
  wire        stop_req  = running && !run_cmd;
  wire [15:0] dec_freq  = ramp_to(out_freq, 16'h0000, ramp_step);
  wire        at_engage = (dec_freq <= eng_freq);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  logic [15:0] next_freq;
  logic        next_release;

  always_comb begin
    next_state   = state;
    next_freq    = out_freq;
    next_release = brake_release;
    tmr_start    = 1'b0;
    tmr_load     = eng_hold;
    if (stop_req) begin
      next_state = mbs_pkg::ST_DECEL;
    end else begin
      case (state)
        mbs_pkg::ST_IDLE: begin
          if (run_cmd)
            next_state = seq_en ? mbs_pkg::ST_ACCEL_REL : mbs_pkg::ST_RUN;
        end
        mbs_pkg::ST_ACCEL_REL: begin
          if (tick)
            next_freq = ramp_to(out_freq, rel_freq, ramp_step);
          if (out_freq == rel_freq)
            next_state = mbs_pkg::ST_WAIT_CURR;
        end
        mbs_pkg::ST_WAIT_CURR: begin
          if (motor_current >= rel_current) begin
            next_release = 1'b1;
            tmr_start    = 1'b1;
            tmr_load     = rel_hold;
            next_state   = mbs_pkg::ST_REL_HOLD;
          end
        end
        mbs_pkg::ST_REL_HOLD: begin
          if (tmr_done)
            next_state = mbs_pkg::ST_RUN;
        end
        mbs_pkg::ST_RUN: begin
          if (tick)
            next_freq = ramp_to(out_freq, target, ramp_step);
        end
        mbs_pkg::ST_DECEL: begin
          if (!seq_en) begin
            if (tick)
              next_freq = dec_freq;
            if (out_freq == 16'h0000)
              next_state = mbs_pkg::ST_IDLE;
          end else if (tick || out_freq <= eng_freq) begin
            next_freq = at_engage ? eng_freq : dec_freq;
            if (at_engage || out_freq <= eng_freq) begin
              next_freq    = (out_freq < eng_freq) ? out_freq : eng_freq;
              next_release = 1'b0;
              tmr_start    = 1'b1;
              next_state   = mbs_pkg::ST_ENG_HOLD;
            end
          end
        end
        mbs_pkg::ST_ENG_HOLD: begin
          if (tmr_done) begin
            next_freq = 16'h0000;
            if (dcb_set) begin
              tmr_start  = 1'b1;
              tmr_load   = dcb_time;
              next_state = mbs_pkg::ST_DC_BRAKE;
            end else begin
              next_state = mbs_pkg::ST_IDLE;
            end
          end
        end
        mbs_pkg::ST_DC_BRAKE: begin
          if (tmr_done)
            next_state = mbs_pkg::ST_BLOCK;
        end
        mbs_pkg::ST_BLOCK: begin
          next_state = mbs_pkg::ST_IDLE;
        end
        default: next_state = mbs_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= mbs_pkg::ST_IDLE;
      out_freq      <= 16'h0000;
      brake_release <= 1'b0;
      out_reverse   <= 1'b0;
    end else begin
      state         <= next_state;
      out_freq      <= next_freq;
      brake_release <= next_release;
      if (state == mbs_pkg::ST_IDLE)
        out_reverse <= rev_cmd;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_brake_active   <= 1'b0;
      dc_brake_level    <= 16'h0000;
      output_block      <= 1'b1;
      start_dcb_inhibit <= 1'b1;
      dwell_inhibit     <= 1'b1;
    end else begin
      dc_brake_active   <= (next_state == mbs_pkg::ST_DC_BRAKE);
      dc_brake_level    <= (next_state == mbs_pkg::ST_DC_BRAKE) ? dcb_level_r : 16'h0000;
      output_block      <= (next_state == mbs_pkg::ST_IDLE) || (next_state == mbs_pkg::ST_BLOCK);
      start_dcb_inhibit <= seq_en;
      dwell_inhibit     <= seq_en;
    end
  end

endmodule // mbs_brake_seq

`default_nettype wire

// ===== hdl/mbs_pkg.sv
package mbs_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_REL_CURRENT = 8'h04;
  localparam logic [7:0] OFS_REL_HOLD    = 8'h08;
  localparam logic [7:0] OFS_REL_FWD     = 8'h0C;
  localparam logic [7:0] OFS_REL_REV     = 8'h10;
  localparam logic [7:0] OFS_ENG_HOLD    = 8'h14;
  localparam logic [7:0] OFS_ENG_FREQ    = 8'h18;
  localparam logic [7:0] OFS_TARGET      = 8'h1C;
  localparam logic [7:0] OFS_MAX_FREQ    = 8'h20;
  localparam logic [7:0] OFS_RAMP_STEP   = 8'h24;
  localparam logic [7:0] OFS_DCB_TIME    = 8'h28;
  localparam logic [7:0] OFS_DCB_LEVEL   = 8'h2C;
  localparam logic [7:0] OFS_STATUS      = 8'h30;

  // ==========================================================================
  // Control and status fields
  // ==========================================================================
  localparam int CTRL_SEQ_EN_BIT  = 0;
  localparam int CTRL_RUN_BIT     = 1;
  localparam int CTRL_REVERSE_BIT = 2;
  localparam int ST_FREQ_LSB      = 0;
  localparam int ST_STATE_LSB     = 16;
  localparam int ST_RELEASE_BIT   = 24;
  localparam int ST_DCB_BIT       = 25;
  localparam int ST_BLOCK_BIT     = 26;

  // ==========================================================================
  // Reset values (frequency 0.01 Hz, time 10 ms, current 0.1 percent)
  // ==========================================================================
  localparam logic [2:0]  RST_CTRL        = 3'h1;
  localparam logic [15:0] RST_REL_CURRENT = 16'h01F4;
  localparam logic [15:0] RST_REL_HOLD    = 16'h0064;
  localparam logic [15:0] RST_REL_FREQ    = 16'h0064;
  localparam logic [15:0] RST_ENG_HOLD    = 16'h0064;
  localparam logic [15:0] RST_ENG_FREQ    = 16'h00C8;
  localparam logic [15:0] RST_TARGET      = 16'h0000;
  localparam logic [15:0] RST_MAX_FREQ    = 16'h1770;
  localparam logic [15:0] RST_RAMP_STEP   = 16'h000A;
  localparam logic [15:0] RST_DCB         = 16'h0000;

  // ==========================================================================
  // Limits
  // ==========================================================================
  localparam logic [15:0] MAX_REL_CURRENT = 16'h0708;
  localparam logic [15:0] MAX_HOLD_TIME   = 16'h03E8;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS  = 10_000_000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ACCEL_REL, ST_WAIT_CURR, ST_REL_HOLD, ST_RUN,
    ST_DECEL, ST_ENG_HOLD, ST_DC_BRAKE, ST_BLOCK
  } mbs_state_e;

endpackage

// ===== hdl/mbs_hold_timer.sv
`timescale 1ns/1ns
`default_nettype none

// Free running 10 ms tick and a tick-based hold counter.
module mbs_hold_timer #(
  parameter int TICK_CYCLES = 1_000_000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [15:0] hold_ticks,
  output logic             tick,
  output logic             done
);

  if (TICK_CYCLES < 2) begin : g_bad_ticks
    $error("TICK_CYCLES must be at least 2");
  end

  logic [31:0] prescale;
  logic [15:0] remain;
  logic        armed;
  wire         wrap = (prescale == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 32'h0000_0000;
      tick     <= 1'b0;
    end else begin
      prescale <= wrap ? 32'h0000_0000 : prescale + 32'h0000_0001;
      tick     <= wrap;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= 16'h0000;
      armed  <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= hold_ticks;
        armed  <= 1'b1;
      end else if (armed && remain == 16'h0000) begin
        armed <= 1'b0;
        done  <= 1'b1;
      end else if (armed && tick) begin
        remain <= remain - 16'h0001;
      end
    end
  end

endmodule // mbs_hold_timer

`default_nettype wire

// ===== bench/mbs_brake_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Motor held by the brake
// ==========================================================================
module mbs_brake_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] out_freq,
  input  wire logic [15:0] load_level,
  input  wire logic        slow,
  output logic      [15:0] motor_current
);

  // Without slow the motor draws current only while the drive puts out a frequency.
  // With slow set the current creeps towards the load, or towards zero at zero frequency, by one unit a cycle.
  wire [15:0] goal = (out_freq != 16'h0000) ? load_level : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_current <= 16'h0000;
    end else if (!slow || motor_current == goal) begin
      motor_current <= goal;
    end else if (motor_current < goal) begin
      motor_current <= motor_current + 16'h0001;
    end else begin
      motor_current <= motor_current - 16'h0001;
    end
  end

endmodule // mbs_brake_model

// ===== bench/mbs_brake_seq_chk.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Port checker
// ==========================================================================
module mbs_brake_seq_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] out_freq,
  input wire logic        out_reverse,
  input wire logic        brake_release,
  input wire logic        dc_brake_active,
  input wire logic [15:0] dc_brake_level,
  input wire logic        output_block,
  input wire logic        start_dcb_inhibit,
  input wire logic        dwell_inhibit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  access_ready_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  inhibit_pair_a: assert property (start_dcb_inhibit == dwell_inhibit)
    else $error("start inhibits disagree");
  release_seq_a: assert property (brake_release |-> start_dcb_inhibit)
    else $error("release without sequencing");
  release_hold_a: assert property ($rose(brake_release) |=> $stable(out_freq)[*8])
    else $error("frequency moved in release hold");
  release_keep_a: assert property (brake_release |-> !output_block && !dc_brake_active)
    else $error("release high while output stopped");
  engage_freq_a: assert property ($fell(brake_release) |-> out_freq <= $past(out_freq))
    else $error("frequency rose at engage");
  engage_hold_a: assert property ($fell(brake_release) |=> $stable(out_freq)[*8])
    else $error("frequency moved in engage hold");
  dcb_zero_a: assert property (dc_brake_active |-> out_freq == 16'h0000 && !brake_release)
    else $error("DC braking above zero frequency");
  dcb_level_a: assert property (!dc_brake_active |-> dc_brake_level == 16'h0000)
    else $error("DC level outside braking");
  dcb_block_a: assert property ($fell(dc_brake_active) |-> ##[0:2] output_block)
    else $error("no block after DC braking");
  dir_latch_a: assert property ($changed(out_reverse) |-> $past(output_block))
    else $error("direction changed while running");

  cover property ($rose(brake_release));
  cover property ($fell(brake_release));
  cover property ($rose(dc_brake_active));
  cover property (pslverr);
endmodule // mbs_brake_seq_chk

`default_nettype wire

// ===== bench/test_motor_brake_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module test_motor_brake_sequencer;
  localparam int TICKS = 10;
  localparam int LIMIT = 20_000;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow, rev;
  logic        out_reverse, brake_release, dc_brake_active, output_block;
  logic        start_dcb_inhibit, dwell_inhibit;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] motor_current, out_freq, dc_brake_level, load_level, rel, eng, tgt, lvl;
  logic [15:0] rst_val [12];
  int          bad_count, n_tests, cycles;

  mbs_brake_seq #(.TICK_CYCLES(TICKS)) mbs_brake_seq_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .motor_current(motor_current), .out_freq(out_freq), .out_reverse(out_reverse),
    .brake_release(brake_release), .dc_brake_active(dc_brake_active),
    .dc_brake_level(dc_brake_level), .output_block(output_block),
    .start_dcb_inhibit(start_dcb_inhibit), .dwell_inhibit(dwell_inhibit)
  );

  mbs_brake_model mbs_brake_model_i (
    .pclk(pclk), .presetn(presetn), .out_freq(out_freq), .load_level(load_level),
    .slow(slow), .motor_current(motor_current)
  );

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the access edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    load_level = 16'h0000;
    slow = 1'b0;
    rst_val = '{{13'h0000, mbs_pkg::RST_CTRL}, mbs_pkg::RST_REL_CURRENT,
      mbs_pkg::RST_REL_HOLD, mbs_pkg::RST_REL_FREQ, mbs_pkg::RST_REL_FREQ,
      mbs_pkg::RST_ENG_HOLD, mbs_pkg::RST_ENG_FREQ, mbs_pkg::RST_TARGET,
      mbs_pkg::RST_MAX_FREQ, mbs_pkg::RST_RAMP_STEP, mbs_pkg::RST_DCB, mbs_pkg::RST_DCB};
    void'($urandom(32'h4e25));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk({brake_release, output_block, start_dcb_inhibit, dwell_inhibit}, 32'h0000_0007);
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      chk(rd, {16'h0000, rst_val[i]});
    end
    apb(1'b0, mbs_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0400_0000);
    apb(1'b0, 8'h34, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, mbs_pkg::OFS_STATUS, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, mbs_pkg::OFS_REL_CURRENT, 32'h0000_ffff);
    apb(1'b0, mbs_pkg::OFS_REL_CURRENT, 32'h0000_0000);
    chk(rd, {16'h0000, mbs_pkg::MAX_REL_CURRENT});
    // Sequencing off lifts both start inhibits.
    apb(1'b1, mbs_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({start_dcb_inhibit, dwell_inhibit}, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      rev = k[0];
      rel = 16'(50 + $urandom % 100);
      eng = 16'(100 + $urandom % 100);
      tgt = 16'(300 + $urandom % 100);
      lvl = 16'(100 + $urandom % 500);
      apb(1'b1, rev ? mbs_pkg::OFS_REL_REV : mbs_pkg::OFS_REL_FWD, {16'h0000, rel});
      apb(1'b1, rev ? mbs_pkg::OFS_REL_FWD : mbs_pkg::OFS_REL_REV, {16'h0000, rel + 16'h0020});
      apb(1'b1, mbs_pkg::OFS_ENG_FREQ, {16'h0000, eng});
      apb(1'b1, mbs_pkg::OFS_TARGET, {16'h0000, tgt});
      apb(1'b1, mbs_pkg::OFS_REL_CURRENT, {16'h0000, lvl});
      apb(1'b1, mbs_pkg::OFS_REL_HOLD, 32'h0000_0003);
      apb(1'b1, mbs_pkg::OFS_ENG_HOLD, 32'h0000_0003);
      apb(1'b1, mbs_pkg::OFS_DCB_TIME, 32'h0000_0004);
      apb(1'b1, mbs_pkg::OFS_DCB_LEVEL, rev ? 32'h0000_0000 : {16'h0000, lvl});
      load_level <= lvl - 16'h0010;
      slow <= rev;
      apb(1'b1, mbs_pkg::OFS_CTRL, {29'h0000_0000, rev, 2'b11});
      while (out_freq !== rel) @(posedge pclk);
      repeat (60) @(posedge pclk);
      chk({out_reverse, brake_release, out_freq}, {14'h0000, rev, 1'b0, rel});
      load_level <= lvl;
      while (brake_release !== 1'b1) @(posedge pclk);
      chk({out_freq, motor_current}, {rel, lvl});
      apb(1'b0, mbs_pkg::OFS_STATUS, 32'h0000_0000);
      chk({28'h000_0000, rd[19:16]}, 32'(mbs_pkg::ST_REL_HOLD));
      while (out_freq !== tgt) @(posedge pclk);
      apb(1'b1, mbs_pkg::OFS_CTRL, {29'h0000_0000, rev, 2'b01});
      while (brake_release !== 1'b0) @(posedge pclk);
      chk(out_freq, eng);
      while (out_freq !== 16'h0000) @(posedge pclk);
      if (!rev) begin
        while (dc_brake_active !== 1'b1) @(posedge pclk);
        chk(dc_brake_level, lvl);
      end else begin
        repeat (20) @(posedge pclk);
        chk({dc_brake_active, output_block}, 32'h0000_0001);
      end
      while (output_block !== 1'b1) @(posedge pclk);
      repeat (5) @(posedge pclk);
    end
    // Sequencing off: plain run and stop, the brake output never moves.
    apb(1'b1, mbs_pkg::OFS_CTRL, 32'h0000_0002);
    while (out_freq !== tgt) @(posedge pclk);
    chk({out_reverse, brake_release, dc_brake_active, output_block}, 32'h0000_0000);
    apb(1'b1, mbs_pkg::OFS_CTRL, 32'h0000_0000);
    while (out_freq !== 16'h0000) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk({brake_release, dc_brake_active, output_block}, 32'h0000_0001);
    finish_test();
  end
endmodule // test_motor_brake_sequencer

bind mbs_brake_seq mbs_brake_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) mbs_brake_seq_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .motor_current(motor_current), .out_freq(out_freq), .out_reverse(out_reverse),
  .brake_release(brake_release), .dc_brake_active(dc_brake_active),
  .dc_brake_level(dc_brake_level), .output_block(output_block),
  .start_dcb_inhibit(start_dcb_inhibit), .dwell_inhibit(dwell_inhibit)
);

`default_nettype wire
